// File: src/wlc_pkg.sv
// Constants, register map and types of the wobble and length counter block.
package wlc_pkg;
    // Clock and timebase.
    localparam int unsigned CLK_PERIOD_NS  = 10;
    localparam int unsigned TICK_PERIOD_NS = 1_000_000;
    localparam int unsigned TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int unsigned MS_PER_UNIT    = 100;
    localparam int unsigned PCT_SCALE      = 1000;
    localparam int unsigned PPM_SCALE      = 10;
    // Register byte offsets.
    localparam logic [11:0] OFS_CTRL   = 12'h000;
    localparam logic [11:0] OFS_CENTRE = 12'h004;
    localparam logic [11:0] OFS_FMAX   = 12'h008;
    localparam logic [11:0] OFS_FUPPER = 12'h00C;
    localparam logic [11:0] OFS_FLOWER = 12'h010;
    localparam logic [11:0] OFS_SWING  = 12'h014;
    localparam logic [11:0] OFS_PERIOD = 12'h018;
    localparam logic [11:0] OFS_RISE   = 12'h01C;
    localparam logic [11:0] OFS_TLEN   = 12'h020;
    localparam logic [11:0] OFS_MLEN   = 12'h024;
    localparam logic [11:0] OFS_PPM    = 12'h028;
    localparam logic [11:0] OFS_FULL   = 12'h02C;
    localparam logic [11:0] OFS_INTER  = 12'h030;
    localparam logic [11:0] OFS_COUNT  = 12'h034;
    localparam logic [11:0] OFS_FOUT   = 12'h038;
    localparam logic [11:0] OFS_STATUS = 12'h03C;
    localparam logic [11:0] OFS_MASK   = 12'h040;
    // Control bit positions.
    localparam int unsigned CTRL_EN_BIT   = 0;
    localparam int unsigned CTRL_REF_BIT  = 1;
    localparam int unsigned CTRL_CCLR_BIT = 2;
    localparam int unsigned CTRL_LCLR_BIT = 3;
    // Values after reset and legal ranges.
    localparam logic [15:0] RST_CENTRE = 16'h1388;
    localparam logic [15:0] RST_FMAX   = 16'h1388;
    localparam logic [15:0] RST_FUPPER = 16'h1388;
    localparam logic [15:0] RST_FLOWER = 16'h0000;
    localparam logic [15:0] RST_SWING  = 16'h0000;
    localparam logic [15:0] RST_KICK   = 16'h0000;
    localparam logic [15:0] RST_PERIOD = 16'h0064;
    localparam logic [15:0] RST_RISE   = 16'h01F4;
    localparam logic [15:0] RST_TLEN   = 16'h03E8;
    localparam logic [15:0] RST_PPM    = 16'h03E8;
    localparam logic [15:0] RST_FULL   = 16'h03E8;
    localparam logic [15:0] RST_INTER  = 16'h03E8;
    localparam logic [15:0] SWING_MAX  = 16'h03E8;
    localparam logic [15:0] KICK_MAX   = 16'h01F4;
    localparam logic [15:0] PERIOD_MIN = 16'h0001;
    localparam logic [15:0] PERIOD_MAX = 16'h7530;
    localparam logic [15:0] RISE_MIN   = 16'h0001;
    localparam logic [15:0] RISE_MAX   = 16'h03E8;
    localparam logic [15:0] ONE_MIN    = 16'h0001;
    localparam logic [15:0] WORD_MAX   = 16'hFFFF;
    // Ramp direction of the triangle.
    typedef enum logic [0:0] {
        WLC_RISE = 1'b0,
        WLC_FALL = 1'b1
    } wlc_phase_t;
    // Sticky event bits, one per interrupt source.
    typedef struct packed {
        logic period_wrap;
        logic inter;
        logic full;
        logic length;
    } wlc_event_t;
endpackage : wlc_pkg

// File: src/wlc_top.sv
// Wobble frequency generator with length and pulse count supervision.
// Notes on behaviour
// - Output swings triangularly around centre frequency.
// - Zero swing percentage gives plain centre.
// - Reference select: 0 centre, 1 maximum.
// - Span equals reference times swing percentage.
// - Kick equals span times kick, max 50%.
// - Kick tracks centre only in mode 0.
// - Output clamped between lower and upper limits.
// - Full period settable 0.1 s to 3000 s.
// - Rise lasts period times rise coefficient.
// - Fall lasts remaining part of period.
// - Length equals pulses divided by pulses-per-metre.
// - Length reached when measured reaches target.
// - Length reset input clears length accumulation.
// - Full count reached flag at target.
// - Intermediate count reached flag at target.
`timescale 1ns/10ps
`default_nettype none
module wlc_top #(
    parameter int unsigned TICK_CYCLES = wlc_pkg::TICK_CYCLES
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        length_pulse_in,
    input  wire logic        length_reset_in,
    input  wire logic        count_pulse_in,
    output logic      [15:0] freq_out,
    output logic             length_reached,
    output logic             full_count_reached,
    output logic             intermediate_count_reached,
    output logic             irq
);
    // Address decode for the error answer; the read mux decodes paddr on its own.
    function automatic logic wlc_mapped(input logic [11:0] a);
        logic hit;
        hit = (a[1:0] == 2'b00) && (a <= wlc_pkg::OFS_MASK);
        return hit;
    endfunction : wlc_mapped

    // Limits a written value to its legal range.
    function automatic logic [15:0] wlc_clip(input logic [15:0] v,
                                             input logic [15:0] lo,
                                             input logic [15:0] hi);
        logic [15:0] r;
        r = v;
        if (v < lo) begin
            r = lo;
        end else if (v > hi) begin
            r = hi;
        end
        return r;
    endfunction : wlc_clip

    logic [15:0] centre_q, fmax_q, upper_q, lower_q, swing_q, kick_q;
    logic [15:0] period_q, rise_q, tlen_q, ppm_q, full_q, inter_q;
    logic        en_q, ref_sel_q;
    logic [15:0] measured_q, count_q, freq_q;
    logic [31:0] len_pulses_q, tick_cnt_q;
    logic [22:0] t_q;
    logic [31:0] prdata_q;
    logic        len_prev_q, cnt_prev_q, irq_q;
    logic        len_rch_q, full_rch_q, inter_rch_q;
    wlc_pkg::wlc_phase_t phase_q;
    wlc_pkg::wlc_event_t status_q, mask_q, ev;
    logic [31:0] rd_mux;

    // APB strobes; every access completes in its first access cycle.
    wire wr_en = psel & penable & pwrite;
    wire w_ctrl = wr_en && (paddr == wlc_pkg::OFS_CTRL);
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~wlc_mapped(paddr);
    assign prdata  = prdata_q;

    // Configuration registers; swing, kick, period, rise, ppm, full and inter are clipped to their legal ranges on write.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_q      <= 1'b0;
            ref_sel_q <= 1'b0;
            centre_q  <= wlc_pkg::RST_CENTRE;
            fmax_q    <= wlc_pkg::RST_FMAX;
            upper_q   <= wlc_pkg::RST_FUPPER;
            lower_q   <= wlc_pkg::RST_FLOWER;
            swing_q   <= wlc_pkg::RST_SWING;
            kick_q    <= wlc_pkg::RST_KICK;
            period_q  <= wlc_pkg::RST_PERIOD;
            rise_q    <= wlc_pkg::RST_RISE;
            tlen_q    <= wlc_pkg::RST_TLEN;
            ppm_q     <= wlc_pkg::RST_PPM;
            full_q    <= wlc_pkg::RST_FULL;
            inter_q   <= wlc_pkg::RST_INTER;
        end else if (wr_en) begin
            if (paddr == wlc_pkg::OFS_CTRL) begin
                en_q      <= pwdata[wlc_pkg::CTRL_EN_BIT];
                ref_sel_q <= pwdata[wlc_pkg::CTRL_REF_BIT];
            end else if (paddr == wlc_pkg::OFS_CENTRE) begin
                centre_q <= pwdata[15:0];
            end else if (paddr == wlc_pkg::OFS_FMAX) begin
                fmax_q <= pwdata[15:0];
            end else if (paddr == wlc_pkg::OFS_FUPPER) begin
                upper_q <= pwdata[15:0];
            end else if (paddr == wlc_pkg::OFS_FLOWER) begin
                lower_q <= pwdata[15:0];
            end else if (paddr == wlc_pkg::OFS_SWING) begin
                swing_q <= wlc_clip(pwdata[15:0], 16'h0000, wlc_pkg::SWING_MAX);
                kick_q  <= wlc_clip(pwdata[31:16], 16'h0000, wlc_pkg::KICK_MAX);
            end else if (paddr == wlc_pkg::OFS_PERIOD) begin
                period_q <= wlc_clip(pwdata[15:0], wlc_pkg::PERIOD_MIN,
                                     wlc_pkg::PERIOD_MAX);
            end else if (paddr == wlc_pkg::OFS_RISE) begin
                rise_q <= wlc_clip(pwdata[15:0], wlc_pkg::RISE_MIN, wlc_pkg::RISE_MAX);
            end else if (paddr == wlc_pkg::OFS_TLEN) begin
                tlen_q <= pwdata[15:0];
            end else if (paddr == wlc_pkg::OFS_PPM) begin
                ppm_q <= wlc_clip(pwdata[15:0], wlc_pkg::ONE_MIN, wlc_pkg::WORD_MAX);
            end else if (paddr == wlc_pkg::OFS_FULL) begin
                full_q <= wlc_clip(pwdata[15:0], wlc_pkg::ONE_MIN, wlc_pkg::WORD_MAX);
            end else if (paddr == wlc_pkg::OFS_INTER) begin
                inter_q <= wlc_clip(pwdata[15:0], wlc_pkg::ONE_MIN, wlc_pkg::WORD_MAX);
            end
        end
    end

    // Read mux, captured in the setup cycle so prdata comes from a flop.
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (paddr == wlc_pkg::OFS_CTRL) begin
            rd_mux = {30'h0000_0000, ref_sel_q, en_q};
        end else if (paddr == wlc_pkg::OFS_CENTRE) begin
            rd_mux = {16'h0000, centre_q};
        end else if (paddr == wlc_pkg::OFS_FMAX) begin
            rd_mux = {16'h0000, fmax_q};
        end else if (paddr == wlc_pkg::OFS_FUPPER) begin
            rd_mux = {16'h0000, upper_q};
        end else if (paddr == wlc_pkg::OFS_FLOWER) begin
            rd_mux = {16'h0000, lower_q};
        end else if (paddr == wlc_pkg::OFS_SWING) begin
            rd_mux = {kick_q, swing_q};
        end else if (paddr == wlc_pkg::OFS_PERIOD) begin
            rd_mux = {16'h0000, period_q};
        end else if (paddr == wlc_pkg::OFS_RISE) begin
            rd_mux = {16'h0000, rise_q};
        end else if (paddr == wlc_pkg::OFS_TLEN) begin
            rd_mux = {16'h0000, tlen_q};
        end else if (paddr == wlc_pkg::OFS_MLEN) begin
            rd_mux = {16'h0000, measured_q};
        end else if (paddr == wlc_pkg::OFS_PPM) begin
            rd_mux = {16'h0000, ppm_q};
        end else if (paddr == wlc_pkg::OFS_FULL) begin
            rd_mux = {16'h0000, full_q};
        end else if (paddr == wlc_pkg::OFS_INTER) begin
            rd_mux = {16'h0000, inter_q};
        end else if (paddr == wlc_pkg::OFS_COUNT) begin
            rd_mux = {16'h0000, count_q};
        end else if (paddr == wlc_pkg::OFS_FOUT) begin
            rd_mux = {16'h0000, freq_q};
        end else if (paddr == wlc_pkg::OFS_STATUS) begin
            rd_mux = {28'h000_0000, status_q};
        end else if (paddr == wlc_pkg::OFS_MASK) begin
            rd_mux = {28'h000_0000, mask_q};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata_q <= rd_mux;
        end
    end

    // Swing span, kick step and triangle endpoints.
    wire         wob_active = en_q && (swing_q != 16'h0000);
    wire  [15:0] ref_f = ref_sel_q ? fmax_q : centre_q;
    wire  [31:0] span_w = (32'(ref_f) * 32'(swing_q)) / wlc_pkg::PCT_SCALE;
    wire  [15:0] span = span_w[15:0];
    wire  [31:0] kick_w = (32'(span) * 32'(kick_q)) / wlc_pkg::PCT_SCALE;
    wire  [15:0] kick = kick_w[15:0];
    wire  [16:0] excur = {span, 1'b0} - 17'(kick);
    wire  [22:0] per_ms = 23'(32'(period_q) * wlc_pkg::MS_PER_UNIT);
    wire  [39:0] rise_w = (40'(per_ms) * 40'(rise_q)) / wlc_pkg::PCT_SCALE;
    wire  [22:0] rise_ms = (rise_w[22:0] == 23'h00_0000) ? 23'h00_0001
                                                          : rise_w[22:0];
    wire  [22:0] fall_ms = per_ms - rise_ms;
    wire  [22:0] dur = (phase_q == wlc_pkg::WLC_RISE) ? rise_ms :
                       ((fall_ms == 23'h00_0000) ? 23'h00_0001 : fall_ms);
    wire  [39:0] ramp_w = (40'(excur) * 40'(t_q)) / 40'(dur);
    wire         tick = (tick_cnt_q == TICK_CYCLES - 1);
    wire         seg_end = tick && ((t_q + 23'h00_0001) >= dur);
    logic signed [19:0] f_raw;
    logic        [15:0] f_clamp;
    logic        [15:0] centre_clamped;

    // Millisecond timebase for the triangle, parked while idle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_q <= 32'h0000_0000;
        end else if (!wob_active || tick) begin
            tick_cnt_q <= 32'h0000_0000;
        end else begin
            tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
        end
    end

    // Triangle phase; a rise of the whole period skips the fall.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_q <= wlc_pkg::WLC_RISE;
            t_q     <= 23'h00_0000;
        end else if (!wob_active) begin
            phase_q <= wlc_pkg::WLC_RISE;
            t_q     <= 23'h00_0000;
        end else if (seg_end) begin
            t_q <= 23'h00_0000;
            case (phase_q)
                wlc_pkg::WLC_RISE: begin
                    if (fall_ms != 23'h00_0000) begin
                        phase_q <= wlc_pkg::WLC_FALL;
                    end
                end
                default: begin
                    phase_q <= wlc_pkg::WLC_RISE;
                end
            endcase
        end else if (tick) begin
            t_q <= t_q + 23'h00_0001;
        end
    end

    // Instantaneous frequency: ramp with a kick at each turn, then clamp.
    always_comb begin
        centre_clamped = centre_q;
        if (centre_q > upper_q) begin
            centre_clamped = upper_q;
        end else if (centre_q < lower_q) begin
            centre_clamped = lower_q;
        end
        if (!wob_active) begin
            f_raw = 20'(centre_q);
        end else if (phase_q == wlc_pkg::WLC_RISE) begin
            f_raw = 20'(centre_q) - 20'(span) + 20'(kick) + 20'(ramp_w[18:0]);
        end else begin
            f_raw = 20'(centre_q) + 20'(span) - 20'(kick) - 20'(ramp_w[18:0]);
        end
        if (f_raw > $signed(20'(upper_q))) begin
            f_clamp = upper_q;
        end else if (f_raw < $signed(20'(lower_q))) begin
            f_clamp = lower_q;
        end else begin
            f_clamp = f_raw[15:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            freq_q <= 16'h0000;
        end else begin
            freq_q <= f_clamp;
        end
    end
    assign freq_out = freq_q;

    // Edge detection of the pulse inputs, which are already synchronous.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            len_prev_q <= 1'b0;
            cnt_prev_q <= 1'b0;
        end else begin
            len_prev_q <= length_pulse_in;
            cnt_prev_q <= count_pulse_in;
        end
    end
    wire len_edge = length_pulse_in & ~len_prev_q;
    wire cnt_edge = count_pulse_in & ~cnt_prev_q;
    wire len_clr = length_reset_in || (w_ctrl && pwdata[wlc_pkg::CTRL_LCLR_BIT]);
    wire cnt_clr = w_ctrl && pwdata[wlc_pkg::CTRL_CCLR_BIT];

    // Length pulse accumulator; a reset request wins over a pulse.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            len_pulses_q <= 32'h0000_0000;
        end else if (len_clr) begin
            len_pulses_q <= 32'h0000_0000;
        end else if (len_edge && (len_pulses_q != 32'hFFFF_FFFF)) begin
            len_pulses_q <= len_pulses_q + 32'h0000_0001;
        end
    end

    // Pulse counter, saturating at its top value.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q <= 16'h0000;
        end else if (cnt_clr) begin
            count_q <= 16'h0000;
        end else if (cnt_edge && (count_q != wlc_pkg::WORD_MAX)) begin
            count_q <= count_q + 16'h0001;
        end
    end

    // Measured length in metres, ppm held in tenths of a pulse.
    wire [35:0] len_m = (36'(len_pulses_q) * wlc_pkg::PPM_SCALE) / 36'(ppm_q);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            measured_q <= 16'h0000;
        end else if (len_m > 36'(wlc_pkg::WORD_MAX)) begin
            measured_q <= wlc_pkg::WORD_MAX;
        end else begin
            measured_q <= len_m[15:0];
        end
    end

    // Reached flags driven to the output terminals.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            len_rch_q   <= 1'b0;
            full_rch_q  <= 1'b0;
            inter_rch_q <= 1'b0;
        end else begin
            len_rch_q   <= (measured_q >= tlen_q);
            full_rch_q  <= (count_q >= full_q);
            inter_rch_q <= (count_q >= inter_q);
        end
    end
    assign length_reached             = len_rch_q;
    assign full_count_reached         = full_rch_q;
    assign intermediate_count_reached = inter_rch_q;

    // Events: flags turning on and period completion.
    always_comb begin
        ev.length      = (measured_q >= tlen_q) && !len_rch_q;
        ev.full        = (count_q >= full_q) && !full_rch_q;
        ev.inter       = (count_q >= inter_q) && !inter_rch_q;
        ev.period_wrap = wob_active && seg_end &&
                         ((phase_q == wlc_pkg::WLC_FALL) || (fall_ms == 23'h00_0000));
    end

    // Sticky status with write-one-to-clear; a new event beats the clear.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_q <= '0;
            mask_q   <= '0;
            irq_q    <= 1'b0;
        end else begin
            if (wr_en && (paddr == wlc_pkg::OFS_STATUS)) begin
                status_q <= (status_q & ~pwdata[3:0]) | ev;
            end else begin
                status_q <= status_q | ev;
            end
            if (wr_en && (paddr == wlc_pkg::OFS_MASK)) begin
                mask_q <= pwdata[3:0];
            end
            irq_q <= |(status_q & mask_q);
        end
    end
    assign irq = irq_q;

    // Checks beside the logic they guard.
    property p_no_swing;
        @(posedge pclk) disable iff (!presetn)
        presetn && (swing_q == 16'h0000) |=> (freq_q == $past(centre_clamped));
    endproperty
    a_no_swing: assert property (p_no_swing) else $error("swing zero not centre");

    property p_upper;
        @(posedge pclk) disable iff (!presetn)
        1'b1 |=> (freq_q <= $past(upper_q));
    endproperty
    a_upper: assert property (p_upper) else $error("output above upper limit");

    property p_kick_half;
        @(posedge pclk) disable iff (!presetn)
        {kick, 1'b0} <= {1'b0, span};
    endproperty
    a_kick_half: assert property (p_kick_half) else $error("kick above half span");

    sequence s_rise_end;
        wob_active && seg_end && (phase_q == wlc_pkg::WLC_RISE) && (fall_ms != 23'h00_0000);
    endsequence
    property p_rise_to_fall;
        @(posedge pclk) disable iff (!presetn)
        s_rise_end |=> (phase_q == wlc_pkg::WLC_FALL) && (t_q == 23'h00_0000);
    endproperty
    a_rise_to_fall: assert property (p_rise_to_fall) else $error("no fall after rise");

    sequence s_fall_end;
        wob_active && seg_end && (phase_q == wlc_pkg::WLC_FALL);
    endsequence
    property p_period_wrap;
        @(posedge pclk) disable iff (!presetn)
        s_fall_end |=> (phase_q == wlc_pkg::WLC_RISE) ##0 status_q.period_wrap;
    endproperty
    a_period_wrap: assert property (p_period_wrap) else $error("period not closed");

    property p_len_reset;
        @(posedge pclk) disable iff (!presetn)
        length_reset_in |=> (len_pulses_q == 32'h0000_0000) ##1 (measured_q == 16'h0000);
    endproperty
    a_len_reset: assert property (p_len_reset) else $error("length not cleared");

    property p_len_reached;
        @(posedge pclk) disable iff (!presetn)
        (measured_q >= tlen_q) |=> length_reached;
    endproperty
    a_len_reached: assert property (p_len_reached) else $error("length flag missing");

    property p_full;
        @(posedge pclk) disable iff (!presetn)
        1'b1 |=> (full_count_reached == ($past(count_q) >= $past(full_q)));
    endproperty
    a_full: assert property (p_full) else $error("full count flag wrong");

    property p_inter;
        @(posedge pclk) disable iff (!presetn)
        $rose(intermediate_count_reached) |-> ($past(count_q) >= $past(inter_q));
    endproperty
    a_inter: assert property (p_inter) else $error("intermediate flag early");

    property p_count_step;
        @(posedge pclk) disable iff (!presetn)
        (cnt_edge && !cnt_clr && (count_q != 16'hFFFF)) |=>
            (count_q == $past(count_q) + 16'h0001);
    endproperty
    a_count_step: assert property (p_count_step) else $error("count not stepped");
endmodule : wlc_top
`default_nettype wire

// File: dv/wlc_pulse_model.sv
// Model of the digital input terminals that feed pulses to the block.
`timescale 1ns/10ps
`default_nettype none
module wlc_pulse_model (
    input  wire logic pclk,
    output logic      length_pulse_in,
    output logic      length_reset_in,
    output logic      count_pulse_in
);
    // Lines rest low so that the first pulse shows a clean rising edge.
    initial begin
        {count_pulse_in, length_pulse_in, length_reset_in} = 3'h0;
    end
    // Sends n pulses, each one cycle high then one cycle low; sel 0 count, 1 length, 2 clear.
    task automatic pulse(input int sel, input int n);
        repeat (n) begin
            @(posedge pclk);
            count_pulse_in  <= (sel == 0);
            length_pulse_in <= (sel == 1);
            length_reset_in <= (sel == 2);
            @(posedge pclk);
            {count_pulse_in, length_pulse_in, length_reset_in} <= 3'h0;
        end
    endtask : pulse
endmodule : wlc_pulse_model
`default_nettype wire

// File: dv/test_wobble_length_counter.sv
// Self-checking bench for the wobble and length counter block.
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("wrong value at %0t: got %h want %h", $time, got, exp); end end
module test_wobble_length_counter;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] freq_out, flo, fhi;
    logic        length_pulse_in, length_reset_in, count_pulse_in;
    logic        length_reached, full_count_reached, intermediate_count_reached;
    int          n_mismatch = 0, check_count = 0, cycles = 0, mn, mx;
    // Wobble cases: centre, maximum, upper, lower, kick; odd rows use the maximum as reference.
    logic [15:0] wcase [5][5] = '{'{16'h03E8, 16'h1388, 16'h041A, 16'h0398, 16'h0000},
        '{16'h03E8, 16'h0190, 16'h0FA0, 16'h0000, 16'h0000},
        '{16'h03E8, 16'h1388, 16'h0FA0, 16'h0000, 16'h01F4},
        '{16'h07D0, 16'h0190, 16'h0FA0, 16'h0000, 16'h01F4},
        '{16'h07D0, 16'h1388, 16'h0FA0, 16'h0000, 16'h01F4}};
    wlc_top #(.TICK_CYCLES(4)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .length_pulse_in, .length_reset_in,
        .count_pulse_in, .freq_out, .length_reached, .full_count_reached,
        .intermediate_count_reached, .irq);
    wlc_pulse_model i_src (.pclk, .length_pulse_in, .length_reset_in, .count_pulse_in);
    // Clock of 10 ns period.
    always #5 pclk = ~pclk;
    // Cuts a hung run short.
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 9000) begin
            n_mismatch++;
            wrap_up();
        end
    end
    // Prints the counts and the verdict, then ends the run.
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : wrap_up
    // One bus transfer; starts just after an edge and holds until pready is seen.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    // Reads a register and compares it.
    task automatic rchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        `CHK(rd, e)
    endtask : rchk
    // Lowest and highest clamped output over one 100 ms period split 50/50, swing 10%.
    function automatic void span_range(input int c, r, up, lo, kp, output int mn, mx);
        int sp, kk, d, f;
        sp = r * 100 / 1000;
        kk = sp * kp / 1000;
        d = 2 * sp - kk;
        mn = 65535;
        mx = 0;
        for (int t = 0; t < 100; t++) begin
            f = (t < 50) ? c - sp + kk + d * t / 50 : c + sp - kk - d * (t - 50) / 50;
            f = (f > up) ? up : (f < lo) ? lo : f;
            mn = (f < mn) ? f : mn;
            mx = (f > mx) ? f : mx;
        end
    endfunction : span_range
    // Main sequence: defaults, counting, length, wobble.
    initial begin
        {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rchk(wlc_pkg::OFS_PERIOD, 32'h0000_0064);
        rchk(wlc_pkg::OFS_RISE, 32'h0000_01F4);
        rchk(wlc_pkg::OFS_PPM, 32'h0000_03E8);
        rchk(wlc_pkg::OFS_TLEN, 32'h0000_03E8);
        `CHK(freq_out, 16'h1388);
        apb(1'b0, 12'h044, 32'h0000_0000);
        `CHK(err, 1'b1);
        apb(1'b1, wlc_pkg::OFS_INTER, 32'h0000_0002);
        apb(1'b1, wlc_pkg::OFS_FULL, 32'h0000_0003);
        apb(1'b1, wlc_pkg::OFS_MASK, 32'h0000_0004);
        i_src.pulse(0, 2);
        repeat (4) @(posedge pclk);
        `CHK(intermediate_count_reached, 1'b1);
        `CHK(full_count_reached, 1'b0);
        `CHK(irq, 1'b1);
        i_src.pulse(0, 1);
        repeat (4) @(posedge pclk);
        `CHK(full_count_reached, 1'b1);
        rchk(wlc_pkg::OFS_COUNT, 32'h0000_0003);
        rchk(wlc_pkg::OFS_STATUS, 32'h0000_0006);
        apb(1'b1, wlc_pkg::OFS_STATUS, 32'h0000_0004);
        rchk(wlc_pkg::OFS_STATUS, 32'h0000_0002);
        `CHK(irq, 1'b0);
        apb(1'b1, wlc_pkg::OFS_CTRL, 32'h0000_0004);
        rchk(wlc_pkg::OFS_COUNT, 32'h0000_0000);
        `CHK(full_count_reached, 1'b0);
        apb(1'b1, wlc_pkg::OFS_PPM, 32'h0000_0014);
        apb(1'b1, wlc_pkg::OFS_TLEN, 32'h0000_0001);
        for (int p = 0; p < 2; p++) begin
            i_src.pulse(1, 1);
            repeat (4) @(posedge pclk);
            `CHK(length_reached, p[0]);
            rchk(wlc_pkg::OFS_MLEN, {31'h0000_0000, p[0]});
        end
        i_src.pulse(2, 1);
        repeat (4) @(posedge pclk);
        rchk(wlc_pkg::OFS_MLEN, 32'h0000_0000);
        `CHK(length_reached, 1'b0);
        i_src.pulse(1, 2);
        apb(1'b1, wlc_pkg::OFS_CTRL, 32'h0000_0008);
        rchk(wlc_pkg::OFS_MLEN, 32'h0000_0000);
        apb(1'b1, wlc_pkg::OFS_PERIOD, 32'h0000_0001);
        apb(1'b1, wlc_pkg::OFS_CTRL, 32'h0000_0001);
        repeat (450) @(posedge pclk);
        `CHK(freq_out, 16'h1388);
        for (int k = 0; k < 5; k++) begin
            apb(1'b1, wlc_pkg::OFS_CENTRE, {16'h0000, wcase[k][0]});
            apb(1'b1, wlc_pkg::OFS_FMAX, {16'h0000, wcase[k][1]});
            apb(1'b1, wlc_pkg::OFS_FUPPER, {16'h0000, wcase[k][2]});
            apb(1'b1, wlc_pkg::OFS_FLOWER, {16'h0000, wcase[k][3]});
            apb(1'b1, wlc_pkg::OFS_SWING, {wcase[k][4], 16'h0064});
            apb(1'b1, wlc_pkg::OFS_CTRL, {30'h0000_0000, k[0], 1'b1});
            repeat (450) @(posedge pclk);
            flo = 16'hFFFF;
            fhi = 16'h0000;
            repeat (450) begin
                @(posedge pclk);
                flo = (freq_out < flo) ? freq_out : flo;
                fhi = (freq_out > fhi) ? freq_out : fhi;
            end
            span_range(wcase[k][0], wcase[k][k[0]], wcase[k][2], wcase[k][3], wcase[k][4], mn, mx);
            `CHK(flo, mn[15:0]);
            `CHK(fhi, mx[15:0]);
        end
        wrap_up();
    end
endmodule : test_wobble_length_counter
`default_nettype wire
